/* File: include/pllovr_map.vh */
// constants for the pll override page register bank
`ifndef PLLOVR_MAP_VH
`define PLLOVR_MAP_VH

// main-map addresses of the indirect access window
`define PLLOVR_ADDR_PAGE_SEL 8'h40
`define PLLOVR_ADDR_PAGE_OFS 8'h41
`define PLLOVR_ADDR_PAGE_DATA 8'h42

// page that holds the override registers
`define PLLOVR_PAGE_OVERRIDE 8'h10

// offsets within the override page
`define PLLOVR_OFS_CONTROLS 8'h47
`define PLLOVR_OFS_SEQ_FORCE 8'h49

// reset values
`define PLLOVR_RST_PAGE_SEL 8'h00
`define PLLOVR_RST_PAGE_OFS 8'h00
`define PLLOVR_RST_CONTROLS 8'h00
`define PLLOVR_RST_SEQ_FORCE 8'h00

// field positions in pll_override_controls
`define PLLOVR_BIT_DIV_RST_OVR 7
`define PLLOVR_BIT_LOCK_FORCE 5
// writable bits of pll_override_controls, reserved bits read zero
`define PLLOVR_MASK_CONTROLS 8'hA0

// field positions in pll_sequencer_force
`define PLLOVR_BIT_SEQ_OVR_EN 4
`define PLLOVR_MSB_FORCED_STATE 3
`define PLLOVR_LSB_FORCED_STATE 0
`define PLLOVR_MASK_SEQ_FORCE 8'h1F

// forced-state codes
`define PLLOVR_STATE_RESET 4'h0
`define PLLOVR_STATE_LOOP_TIMER 4'h6

`endif

/* File: design/pllovr_page_bank.v */
// storage for the two override registers of the override page
`timescale 1ns/1ns
`include "pllovr_map.vh"

module pllovr_page_bank (
    input wire clk,
    input wire rst_n,
    input wire wr_en,
    input wire [7:0] wr_ofs,
    input wire [7:0] wr_data,
    input wire [7:0] rd_ofs,
    output reg [7:0] controls_ff,
    output reg [7:0] seq_force_ff,
    output reg [7:0] rd_data
);

    reg [7:0] nxt_controls;
    reg [7:0] nxt_seq_force;

    always @* begin
        nxt_controls = controls_ff;
        nxt_seq_force = seq_force_ff;
        if (wr_en) begin
            case (wr_ofs)
                // reserved bits are dropped, so a careless write cannot set them
                `PLLOVR_OFS_CONTROLS: begin
                    nxt_controls = wr_data & `PLLOVR_MASK_CONTROLS; // R5 R6 R7 R8
                end
                `PLLOVR_OFS_SEQ_FORCE: begin
                    nxt_seq_force = wr_data & `PLLOVR_MASK_SEQ_FORCE; // R9 R10
                end
                default: begin
                    nxt_controls = controls_ff;
                end
            endcase
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            controls_ff <= `PLLOVR_RST_CONTROLS;
            seq_force_ff <= `PLLOVR_RST_SEQ_FORCE;
        end else begin
            controls_ff <= nxt_controls;
            seq_force_ff <= nxt_seq_force;
        end
    end

    // unused offsets of the page read zero
    always @* begin
        case (rd_ofs)
            `PLLOVR_OFS_CONTROLS: begin
                rd_data = controls_ff;
            end
            `PLLOVR_OFS_SEQ_FORCE: begin
                rd_data = seq_force_ff;
            end
            default: begin
                rd_data = 8'h00;
            end
        endcase
    end

endmodule // pllovr_page_bank

/* File: design/pllovr_regs.v */
// indirect access window and override outputs for the pll controller
//
// How it works
// R1: override page reached only via 0x40-0x42
// R2: 0x40 page, 0x41 offset, 0x42 data
// R3: software holds controller reset, pulses divider
// R4: software writes 0x00 to release sequencer
// R5: bit 7 of 0x47 holds divider reset
// R6: bit 5 of 0x47 forces lock low
// R7: software writes zero to bit 6
// R8: software writes zeros to bits 4:0
// R9: bit 4 of 0x49 enables forced state
// R10: forced code 0000 reset, 0110 loop timer
// R11: reserved forced codes never loaded by software; the bank stores any 4-bit code and drives it on FORCED_STATE
`timescale 1ns/1ns
`include "pllovr_map.vh"

module pllovr_regs (
    input wire SYS_CLK,
    input wire RST_N,
    input wire [7:0] REG_ADDR,
    input wire REG_WR,
    input wire [7:0] REG_WDATA,
    input wire REG_RD,
    output reg [7:0] REG_RDATA,
    output reg REG_RVALID,
    input wire PLL_LOCK_IN,
    output reg LOCK_OUT,
    output reg DIVIDER_RESET_OVERRIDE,
    output reg LOCK_FORCE_ENABLE,
    output reg SEQUENCER_OVERRIDE_ENABLE,
    output reg [3:0] FORCED_STATE,
    output reg FORCE_RESET_STATE,
    output reg FORCE_LOOP_TIMER_STATE
);

    reg [7:0] page_sel_ff;
    reg [7:0] page_ofs_ff;
    reg [7:0] nxt_page_sel;
    reg [7:0] nxt_page_ofs;
    reg lock_meta_ff;
    reg lock_sync_ff;
    reg [7:0] nxt_rdata;
    reg nxt_rvalid;
    wire page_hit;
    wire bank_wr;
    wire [7:0] bank_rdata;
    wire [7:0] controls;
    wire [7:0] seq_force;
    wire [3:0] state_code;
    wire seq_ovr_en;
    wire sel_wr;
    wire ofs_wr;
    wire div_rst_ovr;
    wire lock_force;
    reg nxt_lock_out;
    reg nxt_div_ovr;
    reg nxt_lock_force;
    reg nxt_seq_ovr;
    reg [3:0] nxt_forced_state;
    reg nxt_force_reset;
    reg nxt_force_timer;

    // one compare for every window address, shared by the write decoders
    function addr_match;
        input [7:0] addr;
        input [7:0] target;
        begin
            addr_match = (addr == target);
        end
    endfunction

    // reserved codes match neither force line; the downstream sequencer
    // has no defined behaviour for them
    function forced_hit;
        input en;
        input [3:0] code;
        input [3:0] target;
        begin
            forced_hit = en && (code == target);
        end
    endfunction

    // data port only reaches the page when the override page is selected
    assign page_hit = (page_sel_ff == `PLLOVR_PAGE_OVERRIDE); // R1
    assign sel_wr = REG_WR && addr_match(REG_ADDR, `PLLOVR_ADDR_PAGE_SEL); // R2
    assign ofs_wr = REG_WR && addr_match(REG_ADDR, `PLLOVR_ADDR_PAGE_OFS); // R2
    assign bank_wr = REG_WR && addr_match(REG_ADDR, `PLLOVR_ADDR_PAGE_DATA) &&
        page_hit; // R2

    // writes to other main-map addresses belong to other blocks
    always @* begin
        nxt_page_sel = page_sel_ff;
        nxt_page_ofs = page_ofs_ff;
        if (sel_wr) begin
            nxt_page_sel = REG_WDATA; // R2
        end
        if (ofs_wr) begin
            nxt_page_ofs = REG_WDATA; // R2
        end
    end

    // page select and offset read back exactly as written
    always @(posedge SYS_CLK) begin
        if (!RST_N) begin
            page_sel_ff <= `PLLOVR_RST_PAGE_SEL;
            page_ofs_ff <= `PLLOVR_RST_PAGE_OFS;
        end else begin
            page_sel_ff <= nxt_page_sel;
            page_ofs_ff <= nxt_page_ofs;
        end
    end

    // offset does not auto-increment; repeated data writes hit one register,
    // which is what a write sequence to one offset relies on
    pllovr_page_bank u_bank (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .wr_en(bank_wr),
        .wr_ofs(page_ofs_ff),
        .wr_data(REG_WDATA),
        .rd_ofs(page_ofs_ff),
        .controls_ff(controls),
        .seq_force_ff(seq_force),
        .rd_data(bank_rdata)
    ); // R3 R4

    // read answers only for the three window addresses, so the rest of the
    // main map can be merged on a shared read bus
    always @* begin
        nxt_rdata = 8'h00;
        nxt_rvalid = 1'b0;
        if (REG_RD) begin
            case (REG_ADDR)
                `PLLOVR_ADDR_PAGE_SEL: begin
                    nxt_rdata = page_sel_ff;
                    nxt_rvalid = 1'b1;
                end
                `PLLOVR_ADDR_PAGE_OFS: begin
                    nxt_rdata = page_ofs_ff;
                    nxt_rvalid = 1'b1;
                end
                `PLLOVR_ADDR_PAGE_DATA: begin
                    nxt_rdata = page_hit ? bank_rdata : 8'h00; // R1
                    nxt_rvalid = 1'b1;
                end
                default: begin
                    nxt_rvalid = 1'b0;
                end
            endcase
        end
    end

    // lock comes from the analog pll, outside this clock
    // only the second flop feeds logic; the first may still be settling
    always @(posedge SYS_CLK) begin
        if (!RST_N) begin
            lock_meta_ff <= 1'b0;
            lock_sync_ff <= 1'b0;
        end else begin
            lock_meta_ff <= PLL_LOCK_IN;
            lock_sync_ff <= lock_meta_ff;
        end
    end

    assign state_code = seq_force[`PLLOVR_MSB_FORCED_STATE:`PLLOVR_LSB_FORCED_STATE];
    assign seq_ovr_en = seq_force[`PLLOVR_BIT_SEQ_OVR_EN];
    assign div_rst_ovr = controls[`PLLOVR_BIT_DIV_RST_OVR];
    assign lock_force = controls[`PLLOVR_BIT_LOCK_FORCE];

    // next values of the registered outputs, taken from the bank and, for LOCK_OUT, the synchronised lock
    always @* begin
        nxt_div_ovr = div_rst_ovr; // R5
        nxt_lock_force = lock_force; // R6
        nxt_lock_out = lock_sync_ff & ~lock_force; // R6
        nxt_seq_ovr = seq_ovr_en; // R9
        nxt_forced_state = state_code;
        nxt_force_reset = forced_hit(seq_ovr_en, state_code, `PLLOVR_STATE_RESET); // R10 R11
        nxt_force_timer = forced_hit(seq_ovr_en, state_code,
            `PLLOVR_STATE_LOOP_TIMER); // R10 R11
    end

    // read answer register; rdata stays zero whenever rvalid is low,
    // which a merged read bus relies on
    always @(posedge SYS_CLK) begin
        if (!RST_N) begin
            REG_RDATA <= 8'h00;
            REG_RVALID <= 1'b0;
        end else begin
            REG_RDATA <= nxt_rdata;
            REG_RVALID <= nxt_rvalid;
        end
    end

    // the lock force wins over a locked pll
    always @(posedge SYS_CLK) begin
        if (!RST_N) begin
            LOCK_OUT <= 1'b0;
        end else begin
            LOCK_OUT <= nxt_lock_out; // R6
        end
    end

    // overrides follow the bank one clock later, so that each output
    // comes straight from a flop
    always @(posedge SYS_CLK) begin
        if (!RST_N) begin
            DIVIDER_RESET_OVERRIDE <= 1'b0;
            LOCK_FORCE_ENABLE <= 1'b0;
            SEQUENCER_OVERRIDE_ENABLE <= 1'b0;
            FORCED_STATE <= `PLLOVR_STATE_RESET;
            FORCE_RESET_STATE <= 1'b0;
            FORCE_LOOP_TIMER_STATE <= 1'b0;
        end else begin
            DIVIDER_RESET_OVERRIDE <= nxt_div_ovr; // R5
            LOCK_FORCE_ENABLE <= nxt_lock_force; // R6
            SEQUENCER_OVERRIDE_ENABLE <= nxt_seq_ovr; // R9
            FORCED_STATE <= nxt_forced_state; // R10
            FORCE_RESET_STATE <= nxt_force_reset; // R10
            FORCE_LOOP_TIMER_STATE <= nxt_force_timer; // R10
        end
    end

endmodule // pllovr_regs

/* File: sim/pllovr_regs_asserts.sv */
// port-level checks for the pll override register bank
`timescale 1ns/1ns
module pllovr_regs_asserts (
    input wire SYS_CLK,
    input wire RST_N,
    input wire [7:0] REG_ADDR,
    input wire REG_WR,
    input wire [7:0] REG_WDATA,
    input wire REG_RD,
    input wire [7:0] REG_RDATA,
    input wire REG_RVALID,
    input wire PLL_LOCK_IN,
    input wire LOCK_OUT,
    input wire DIVIDER_RESET_OVERRIDE,
    input wire LOCK_FORCE_ENABLE,
    input wire SEQUENCER_OVERRIDE_ENABLE,
    input wire [3:0] FORCED_STATE,
    input wire FORCE_RESET_STATE,
    input wire FORCE_LOOP_TIMER_STATE
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    // only 0x40..0x42 belong to the window
    wire own = REG_ADDR[7:2] == 6'h10 && REG_ADDR[1:0] != 2'b11;
    wire data_wr = REG_WR && REG_ADDR == 8'h42;
    // mirror of page select and offset, kept from the bus alone
    reg [7:0] page_m = 8'h00;
    reg [7:0] ofs_m = 8'h00;
    always @(posedge SYS_CLK) begin
        if (!RST_N) begin
            page_m <= 8'h00;
            ofs_m <= 8'h00;
        end else if (REG_WR && REG_ADDR == 8'h40) begin
            page_m <= REG_WDATA;
        end else if (REG_WR && REG_ADDR == 8'h41) begin
            ofs_m <= REG_WDATA;
        end
    end
    wire ctl_wr = data_wr && page_m == 8'h10 && ofs_m == 8'h47;
    wire seq_wr = data_wr && page_m == 8'h10 && ofs_m == 8'h49;
    a_read_answer: assert property (REG_RD && !REG_WR && own |=> REG_RVALID)
        else $error("read of window not answered");
    a_answer_cause: assert property (REG_RVALID |-> $past(REG_RD) && $past(own))
        else $error("read answer without window read");
    a_idle_data: assert property (!REG_RVALID |-> REG_RDATA == 8'h00)
        else $error("read data not zero when idle");
    a_write_silent: assert property (REG_WR && !REG_RD |=> !REG_RVALID)
        else $error("write produced a read answer");
    a_lock_forced: assert property (LOCK_FORCE_ENABLE |-> !LOCK_OUT)
        else $error("lock not forced low");
    a_lock_latency: assert property ($rose(LOCK_OUT) |-> $past(PLL_LOCK_IN, 3))
        else $error("lock rose without input lock");
    a_div_write: assert property ($changed(DIVIDER_RESET_OVERRIDE) |-> $past(ctl_wr, 2))
        else $error("divider override changed without write");
    a_seq_write: assert property ($changed({SEQUENCER_OVERRIDE_ENABLE, FORCED_STATE})
        |-> $past(seq_wr, 2))
        else $error("sequencer override changed without write");
    a_force_reset: assert property (FORCE_RESET_STATE ==
        (SEQUENCER_OVERRIDE_ENABLE && FORCED_STATE == 4'h0))
        else $error("reset state force mismatch");
    a_force_timer: assert property (FORCE_LOOP_TIMER_STATE ==
        (SEQUENCER_OVERRIDE_ENABLE && FORCED_STATE == 4'h6))
        else $error("loop timer force mismatch");
    cover property (REG_RVALID && REG_RDATA != 8'h00);
    cover property ($rose(DIVIDER_RESET_OVERRIDE));
    cover property ($rose(FORCE_LOOP_TIMER_STATE));
    cover property ($rose(FORCE_RESET_STATE));
    cover property ($fell(LOCK_OUT) && LOCK_FORCE_ENABLE);
endmodule // pllovr_regs_asserts

bind pllovr_regs pllovr_regs_asserts u_chk (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
    .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .PLL_LOCK_IN(PLL_LOCK_IN),
    .LOCK_OUT(LOCK_OUT), .DIVIDER_RESET_OVERRIDE(DIVIDER_RESET_OVERRIDE),
    .LOCK_FORCE_ENABLE(LOCK_FORCE_ENABLE), .FORCED_STATE(FORCED_STATE),
    .SEQUENCER_OVERRIDE_ENABLE(SEQUENCER_OVERRIDE_ENABLE),
    .FORCE_RESET_STATE(FORCE_RESET_STATE), .FORCE_LOOP_TIMER_STATE(FORCE_LOOP_TIMER_STATE));

/* File: sim/tb.sv */
// self-checking bench for the pll override register bank
`timescale 1ns/1ns
module tb;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg lock = 1'b1;
    reg [7:0] addr = 8'h00;
    reg [7:0] wdata = 8'h00;
    wire [7:0] rdata;
    wire rvalid, lock_out, div, lockf, seq, f_rst, f_tmr;
    wire [3:0] fs;
    wire [9:0] outs = {div, lockf, lock_out, seq, fs, f_rst, f_tmr};
    wire [9:0] rdv = {1'b0, rvalid, rdata};
    integer err_count = 0;
    integer n_tests = 0;
    initial forever #20 clk = ~clk;
    pllovr_regs u_dut (.SYS_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WR(wr),
        .REG_WDATA(wdata), .REG_RD(rd), .REG_RDATA(rdata), .REG_RVALID(rvalid),
        .PLL_LOCK_IN(lock), .LOCK_OUT(lock_out), .DIVIDER_RESET_OVERRIDE(div),
        .LOCK_FORCE_ENABLE(lockf), .SEQUENCER_OVERRIDE_ENABLE(seq), .FORCED_STATE(fs),
        .FORCE_RESET_STATE(f_rst), .FORCE_LOOP_TIMER_STATE(f_tmr));
    task chk(input string nm, input [9:0] seen, input [9:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("ERROR %0s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task cyc;
        @(posedge clk);
        #1;
    endtask
    // idle cycle after each access keeps strobes from toggling twice in one step
    task wr1(input [7:0] a, input [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        cyc;
        wr = 1'b0;
        cyc;
    endtask
    task rd1(input [7:0] a, input [9:0] e);
        addr = a;
        rd = 1'b1;
        cyc;
        rd = 1'b0;
        chk("rdata", rdv, e);
        cyc;
    endtask
    task po(input [7:0] d, input [9:0] e);
        wr1(8'h42, d);
        chk("outs", outs, e);
    endtask
    task tally_and_finish;
        if (err_count == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (3) cyc;
        chk("outs", outs, 10'h000);
        rst_n = 1'b1;
        rd1(8'h40, 10'h100);
        rd1(8'h41, 10'h100);
        wr1(8'h40, 8'h10);
        wr1(8'h41, 8'h49);
        rd1(8'h42, 10'h100);
        po(8'h16, 10'h0D9);
        rd1(8'h42, 10'h116);
        wr1(8'h41, 8'h47);
        rd1(8'h42, 10'h100);
        po(8'h20, 10'h159);
        po(8'hA0, 10'h359);
        po(8'h20, 10'h159);
        po(8'h00, 10'h0D9);
        wr1(8'h41, 8'h49);
        po(8'h00, 10'h080);
        po(8'hFF, 10'h0FC);
        rd1(8'h42, 10'h11F);
        po(8'h10, 10'h0C2);
        wr1(8'h41, 8'h47);
        po(8'hFF, 10'h342);
        rd1(8'h42, 10'h1A0);
        wr1(8'h40, 8'h11);
        po(8'h55, 10'h342);
        rd1(8'h42, 10'h100);
        wr1(8'h40, 8'h10);
        rd1(8'h42, 10'h1A0);
        wr1(8'h41, 8'h48);
        po(8'hFF, 10'h342);
        rd1(8'h42, 10'h100);
        wr1(8'h43, 8'h47);
        rd1(8'h43, 10'h000);
        rd1(8'h41, 10'h148);
        rst_n = 1'b0;
        repeat (3) cyc;
        chk("outs", outs, 10'h000);
        rst_n = 1'b1;
        rd1(8'h40, 10'h100);
        wr1(8'h40, 8'h10);
        wr1(8'h41, 8'h47);
        rd1(8'h42, 10'h100);
        chk("outs", outs, 10'h080);
        lock = 1'b0;
        repeat (4) cyc;
        chk("outs", outs, 10'h000);
        tally_and_finish;
    end
endmodule // tb
